//--- rtl/otp_pkg.sv
/*
 * Package for the programming and verification port of the one-time code store.
 * Assumes a 100 MHz system clock and pins already resolved to logic levels.
 */
package otp_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned CODE_AW  = 12;
  localparam int unsigned CODE_DEPTH = 4096;
  localparam int unsigned KEY_AW   = 6;
  localparam int unsigned KEY_DEPTH = 64;

  // ****************************************************************
  // Fixed locations and values
  // ****************************************************************
  localparam logic [15:0] SIG_MAKER_ADDR = 16'h0030;
  localparam logic [15:0] SIG_PART_ADDR  = 16'h0031;
  localparam logic [15:0] KEY_LAST_ADDR  = 16'h001f;
  // Arbitrary identification values
  localparam logic [7:0]  SIG_MAKER_VAL  = 8'h5a;
  localparam logic [7:0]  SIG_PART_VAL   = 8'ha5;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam logic [2:0]  PULSES_PER_LOC = 3'h5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned PULSE_MIN_US    = 90;
  localparam int unsigned PULSE_MIN_CYC   = PULSE_MIN_US * CLK_MHZ;
  localparam int unsigned CNT_W           = 14;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_IDLE     = 3'b000,
    MODE_PGM_CODE = 3'b001,
    MODE_PGM_KEY  = 3'b010,
    MODE_PGM_LB1  = 3'b011,
    MODE_PGM_LB2  = 3'b100,
    MODE_PGM_LB3  = 3'b101,
    MODE_PGM_SIX  = 3'b110,
    MODE_READ     = 3'b111
  } otp_mode_t;

  typedef struct packed {
    logic        rst;
    logic        fetch_n;
    logic        strobe;
    logic        supply_hi;
    logic        supply_pgm;
    logic        p27;
    logic        p26;
    logic        p37;
    logic        p36;
    logic        p33;
  } otp_pins_t;

  typedef struct packed {
    logic        lb1;
    logic        lb2;
    logic        lb3;
    logic        six_clk;
    logic        key_set;
  } otp_lock_t;

endpackage

//--- rtl/otp_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes a single system clock; input is asynchronous.
 */
module otp_sync
  import otp_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } otp_sync_st_t;

  otp_sync_st_t st_ff;
  otp_sync_st_t nxt_st;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.s1  = i_async;
    nxt_st.s2  = st_ff.s1;
    nxt_st.s3  = st_ff.s2;
    // Change counts once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.val[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sync = st_ff.val;

endmodule

//--- rtl/otp_port.sv
/*
 * Programming and verify port of the one-time code store: mode decode,
 * five-pulse writes, lock bits, encrypted verify and signature reads.
 * Assumes pin levels arrive asynchronously and the programmer holds
 * address, data and mode stable over the five pulses.
 */
// Behaviour
// - Code write pin pattern decoded
// - Key table write decoded, never stored: P2.7 high is addr bit 15, so addr is never within 0..1F
// - Lock bit patterns decoded and programmed
// - Any lock bit blocks code, key writes
// - Six-clock bit uses pattern three, P3.3 low
// - Verify read pin pattern decoded
// - Verify drives code when bits two, three clear
// - Verify output XNOR with key byte
// - Key table never read out
// - Signature bytes at 30h, 31h
// - Bit one blocks external table reads, latches access
// - Bit two also disables verify
// - Bit three blocks external execution, data RAM
// - Key array resets to all ones
// - Only ordered lock sequence honoured
module otp_port
  import otp_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  input  wire logic        I_RST_PIN,
  input  wire logic        I_CODE_FETCH_STROBE_N,
  input  wire logic        I_LATCH_PROGRAM_STROBE_N,
  input  wire logic        I_SUPPLY_HIGH,
  input  wire logic        I_SUPPLY_PGM,
  input  wire logic [7:0]  I_PORT1,
  input  wire logic [7:0]  I_PORT2,
  input  wire logic [7:0]  I_PORT3,
  input  wire logic [7:0]  I_PORT0,
  input  wire logic        I_EXTERNAL_ACCESS_SELECT,
  output logic      [7:0]  O_PORT0,
  output logic      [7:0]  O_PORT0_OE_N,
  output logic             O_LOCK_BIT_ONE,
  output logic             O_LOCK_BIT_TWO,
  output logic             O_LOCK_BIT_THREE,
  output logic             O_SIX_CLOCK,
  output logic             O_EXT_TABLE_READ_BLOCK,
  output logic             O_EXT_ACCESS_LATCHED,
  output logic             O_EXT_EXEC_BLOCK,
  output logic             O_DATA_RAM_BLOCK
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  localparam int unsigned PIN_W = 10 + 16 + 8 + 1;
  logic [PIN_W-1:0] pins_s;
  otp_pins_t        pins;
  logic [15:0]      addr;
  logic [7:0]       wdata;
  logic             ea_pin;

  otp_sync #(.W(PIN_W)) u_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_async ({I_RST_PIN, I_CODE_FETCH_STROBE_N, I_LATCH_PROGRAM_STROBE_N,
               I_SUPPLY_HIGH, I_SUPPLY_PGM, I_PORT2[7], I_PORT2[6],
               I_PORT3[7], I_PORT3[6], I_PORT3[3], I_PORT2, I_PORT1,
               I_PORT0, I_EXTERNAL_ACCESS_SELECT}),
    .o_sync  (pins_s)
  );

  assign pins   = otp_pins_t'(pins_s[PIN_W-1 -: 10]);
  assign addr   = pins_s[24:9];
  assign wdata  = pins_s[8:1];
  assign ea_pin = pins_s[0];

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  otp_mode_t mode;
  logic      base_ok;

  always_comb begin
    base_ok = pins.rst && !pins.fetch_n;
    mode    = MODE_IDLE;
    if (base_ok && pins.supply_pgm) begin
      unique case ({pins.p27, pins.p26, pins.p37, pins.p36})
        4'b1011: mode = MODE_PGM_CODE;
        4'b1010: mode = MODE_PGM_KEY;
        4'b1111: mode = MODE_PGM_LB1;
        4'b1100: mode = MODE_PGM_LB2;
        4'b0101: mode = pins.p33 ? MODE_PGM_LB3 : MODE_PGM_SIX;
        default: mode = MODE_IDLE;
      endcase
    end else if (base_ok && pins.supply_hi && pins.strobe && !pins.p27 && !pins.p26) begin
      mode = MODE_READ;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    otp_lock_t        lock;
    logic [2:0]       pulses;
    logic [CNT_W-1:0] low_cnt;
    logic             strobe_d;
    logic             ea_latched;
    logic [7:0]       dout;
    logic [7:0]       oe_n;
    logic             rst_d;
  } otp_st_t;

  otp_st_t    st_ff;
  otp_st_t    nxt_st;
  logic [7:0] code_mem [CODE_DEPTH];
  logic [7:0] key_mem  [KEY_DEPTH];
  logic [7:0] code_rd;
  logic [7:0] key_rd;
  logic       commit;
  logic       pulse_done;
  logic       any_lock;

  assign code_rd  = code_mem[addr[CODE_AW-1:0]];
  // Key chosen by low address bits; never routed alone to port 0
  assign key_rd   = key_mem[addr[KEY_AW-1:0]];
  assign any_lock = st_ff.lock.lb1 | st_ff.lock.lb2 | st_ff.lock.lb3;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.strobe_d = pins.strobe;
    nxt_st.rst_d    = pins.rst;
    pulse_done      = 1'b0;
    commit          = 1'b0;
    if (mode == MODE_IDLE || mode == MODE_READ) begin
      nxt_st.pulses  = '0;
      nxt_st.low_cnt = '0;
    end else if (!pins.strobe) begin
      if (st_ff.low_cnt != '1) begin
        nxt_st.low_cnt = st_ff.low_cnt + 1'b1;
      end
    end else if (!st_ff.strobe_d) begin
      // Short glitches are not counted as pulses
      pulse_done     = (st_ff.low_cnt >= CNT_W'(PULSE_MIN_CYC));
      nxt_st.low_cnt = '0;
      if (pulse_done) begin
        if (st_ff.pulses == PULSES_PER_LOC - 3'h1) begin
          nxt_st.pulses = '0;
          commit        = 1'b1;
        end else begin
          nxt_st.pulses = st_ff.pulses + 3'h1;
        end
      end
    end
    if (commit) begin
      unique case (mode)
        MODE_PGM_KEY: begin
          if (!any_lock) begin
            nxt_st.lock.key_set = 1'b1;
          end
        end
        MODE_PGM_LB1: nxt_st.lock.lb1 = 1'b1;
        // Out-of-order bits ignored
        MODE_PGM_LB2: nxt_st.lock.lb2 = st_ff.lock.lb1;
        MODE_PGM_LB3: nxt_st.lock.lb3 = st_ff.lock.lb2;
        MODE_PGM_SIX: nxt_st.lock.six_clk = 1'b1;
        default: ;
      endcase
    end
    // Access pin caught on reset release once bit one is set
    if (st_ff.rst_d && !pins.rst && st_ff.lock.lb1) begin
      nxt_st.ea_latched = ea_pin;
    end
    nxt_st.oe_n = 8'hff;
    nxt_st.dout = 8'h00;
    if (mode == MODE_READ) begin
      if (!pins.p37 && !pins.p36) begin
        if (addr == SIG_MAKER_ADDR) begin
          nxt_st.dout = SIG_MAKER_VAL;
          nxt_st.oe_n = 8'h00;
        end else if (addr == SIG_PART_ADDR) begin
          nxt_st.dout = SIG_PART_VAL;
          nxt_st.oe_n = 8'h00;
        end
      end else if (pins.p37 && pins.p36 && !st_ff.lock.lb2 && !st_ff.lock.lb3) begin
        nxt_st.dout = st_ff.lock.key_set ? ~(code_rd ^ key_rd) : code_rd;
        nxt_st.oe_n = 8'h00;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Arrays
  // ****************************************************************
  // No reset on code array: it models unprogrammed cells at all ones
  initial begin
    for (int i = 0; i < CODE_DEPTH; i++) begin
      code_mem[i] = ERASED_BYTE;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      for (int i = 0; i < KEY_DEPTH; i++) begin
        key_mem[i] <= ERASED_BYTE;
      end
    end else if (commit && mode == MODE_PGM_KEY && !any_lock
                 && addr <= KEY_LAST_ADDR) begin
      key_mem[addr[KEY_AW-1:0]] <= wdata;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (commit && mode == MODE_PGM_CODE && !any_lock) begin
      code_mem[addr[CODE_AW-1:0]] <= wdata;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_PORT0                = st_ff.dout;
  assign O_PORT0_OE_N           = st_ff.oe_n;
  assign O_LOCK_BIT_ONE         = st_ff.lock.lb1;
  assign O_LOCK_BIT_TWO         = st_ff.lock.lb2;
  assign O_LOCK_BIT_THREE       = st_ff.lock.lb3;
  assign O_SIX_CLOCK            = st_ff.lock.six_clk;
  assign O_EXT_TABLE_READ_BLOCK = st_ff.lock.lb1;
  assign O_EXT_ACCESS_LATCHED   = st_ff.ea_latched;
  assign O_EXT_EXEC_BLOCK       = st_ff.lock.lb3;
  assign O_DATA_RAM_BLOCK       = st_ff.lock.lb3;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_lock_blocks_key: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    any_lock |=> $stable(st_ff.lock.key_set)) else $error("key flag changed under lock");
  chk_verify_disabled: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (mode == MODE_READ && pins.p36 && st_ff.lock.lb2) |=> st_ff.oe_n == 8'hff)
    else $error("verify drove port while disabled");
  chk_verify_drives: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (mode == MODE_READ && pins.p37 && pins.p36 && !any_lock) |=> st_ff.oe_n == 8'h00)
    else $error("verify did not drive port");
  chk_lock_order: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $rose(st_ff.lock.lb2) |-> $past(st_ff.lock.lb1)) else $error("bit two before one");
  chk_five_pulses: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    commit |-> st_ff.pulses == 3'h4 && pulse_done) else $error("commit without five pulses");
  chk_sig_maker: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (mode == MODE_READ && !pins.p37 && !pins.p36 && addr == SIG_MAKER_ADDR)
    |=> st_ff.dout == SIG_MAKER_VAL) else $error("wrong maker byte");
  chk_exec_block: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    st_ff.lock.lb3 |-> O_EXT_EXEC_BLOCK && O_DATA_RAM_BLOCK && O_EXT_TABLE_READ_BLOCK)
    else $error("bit three restrictions missing");
  chk_short_pulse: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (pins.strobe && !st_ff.strobe_d && st_ff.low_cnt < CNT_W'(PULSE_MIN_CYC)) |-> !commit)
    else $error("short pulse committed");

endmodule

//--- dv/otp_prog_model.sv
/*
 * Programmer model: drives mode pins, strobe, address and data of the port.
 * Assumes its tasks are called from the bench on the system clock.
 */
module otp_prog_model
  import otp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_q,
  input  wire logic [7:0] i_oe_n,
  output logic            o_rst_pin,
  output logic            o_fetch_n,
  output logic            o_strobe_n,
  output logic            o_sup_hi,
  output logic            o_sup_pgm,
  output logic            o_ea,
  output logic [7:0]      o_p1,
  output logic [7:0]      o_p2,
  output logic [7:0]      o_p3,
  output logic [7:0]      o_p0
);
  // ****************************************
  // Pins
  // ****************************************
  logic [7:0] drv;
  logic       drv_en;

  // Pull-ups hold released bits high
  assign o_p0 = drv_en ? drv : (i_q | i_oe_n);

  // System clock stands in for the oscillator
  initial begin
    {o_rst_pin, o_fetch_n, o_strobe_n, o_sup_hi, o_sup_pgm, o_ea} = 6'h28;
    o_p1 = 8'h00;
    o_p2 = 8'h00;
    o_p3 = 8'hff;
    drv = 8'h00;
    drv_en = 1'b0;
  end

  // Pattern is {P2.7, P2.6, P3.7, P3.6}
  task automatic setup(input logic [3:0] pat, input logic p33, input logic [15:0] a);
    @(negedge i_clk);
    o_p1 = a[7:0];
    o_p2 = {pat[3:2], a[13:8]};
    o_p3 = {pat[1:0], 2'h3, p33, 3'h7};
  endtask

  task automatic write_loc(input logic [3:0] pat, input logic p33, input logic [15:0] a,
                           input logic [7:0] d, input int low_cyc);
    setup(pat, p33, a);
    drv = d;
    drv_en = 1'b1;
    o_sup_pgm = 1'b1;
    // Pins settle well before the first pulse
    repeat (20) @(negedge i_clk);
    repeat (5) begin
      o_strobe_n = 1'b0;
      repeat (low_cyc) @(negedge i_clk);
      o_strobe_n = 1'b1;
      repeat (1000) @(negedge i_clk);
    end
    o_sup_pgm = 1'b0;
    drv_en = 1'b0;
    repeat (20) @(negedge i_clk);
  endtask

  task automatic read_loc(input logic [3:0] pat, input logic [15:0] a,
                          output logic [7:0] q, output logic [7:0] oe_n);
    setup(pat, 1'b1, a);
    o_sup_hi = 1'b1;
    repeat (10) @(negedge i_clk);
    q = o_p0;
    oe_n = i_oe_n;
    o_sup_hi = 1'b0;
    repeat (10) @(negedge i_clk);
  endtask

  task automatic pulse_reset(input logic ea);
    @(negedge i_clk);
    o_ea = ea;
    repeat (10) @(negedge i_clk);
    o_rst_pin = 1'b0;
    repeat (10) @(negedge i_clk);
    o_rst_pin = 1'b1;
    repeat (10) @(negedge i_clk);
  endtask
endmodule

//--- dv/otp_port_tb.sv
/*
 * Bench for the programming port: reads, writes, lock bit and access latch.
 * Assumes the programmer model drives every pin of the port.
 */
module otp_port_tb
  import otp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Wiring
  // ****************************************
  logic       clk, rst_n;
  logic       rst_pin, fetch_n, strobe_n, sup_hi, sup_pgm, ea;
  logic [7:0] p0, p1, p2, p3, q, oe_n, rd, rd_oe;
  logic       lb1, lb2, lb3, six, trb, eal, exb, drb;
  int         err_count = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  otp_prog_model prog (.i_clk(clk), .i_q(q), .i_oe_n(oe_n), .o_rst_pin(rst_pin),
    .o_fetch_n(fetch_n), .o_strobe_n(strobe_n), .o_sup_hi(sup_hi), .o_sup_pgm(sup_pgm),
    .o_ea(ea), .o_p1(p1), .o_p2(p2), .o_p3(p3), .o_p0(p0));

  otp_port uut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_RST_PIN(rst_pin),
    .I_CODE_FETCH_STROBE_N(fetch_n), .I_LATCH_PROGRAM_STROBE_N(strobe_n),
    .I_SUPPLY_HIGH(sup_hi), .I_SUPPLY_PGM(sup_pgm), .I_PORT1(p1), .I_PORT2(p2),
    .I_PORT3(p3), .I_PORT0(p0), .I_EXTERNAL_ACCESS_SELECT(ea), .O_PORT0(q),
    .O_PORT0_OE_N(oe_n), .O_LOCK_BIT_ONE(lb1), .O_LOCK_BIT_TWO(lb2),
    .O_LOCK_BIT_THREE(lb3), .O_SIX_CLOCK(six), .O_EXT_TABLE_READ_BLOCK(trb),
    .O_EXT_ACCESS_LATCHED(eal), .O_EXT_EXEC_BLOCK(exb), .O_DATA_RAM_BLOCK(drb));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [3:0] pat, input logic [15:0] a,
                        input logic [7:0] d, input logic [7:0] e_oe);
    prog.read_loc(pat, a, rd, rd_oe);
    check(rd, d);
    check(rd_oe, e_oe);
  endtask

  // Two full writes take about 101k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 130000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    check({lb1, lb2, lb3, six, trb, eal, exb, drb}, 8'h00);
    check(oe_n, 8'hff);
    $display("test reset done");
    rd_chk(4'h3, 16'h0123, 8'hff, 8'h00);
    rd_chk(4'h0, SIG_MAKER_ADDR, SIG_MAKER_VAL, 8'h00);
    rd_chk(4'h0, SIG_PART_ADDR, SIG_PART_VAL, 8'h00);
    rd_chk(4'h0, 16'h0032, 8'hff, 8'hff);
    $display("test reads done");
    prog.write_loc(4'hb, 1'b1, 16'h0123, 8'h3c, 200);
    rd_chk(4'h3, 16'h0123, 8'hff, 8'h00);
    prog.write_loc(4'hb, 1'b1, 16'h0123, 8'h3c, 9100);
    rd_chk(4'h3, 16'h0123, 8'h3c, 8'h00);
    rd_chk(4'h3, 16'h0124, 8'hff, 8'h00);
    $display("test code write done");
    prog.pulse_reset(1'b1);
    check({7'h00, eal}, 8'h00);
    prog.write_loc(4'hf, 1'b1, 16'h0000, 8'hff, 9100);
    check({2'h0, lb1, lb2, lb3, trb, exb, drb}, 8'h24);
    rd_chk(4'h3, 16'h0123, 8'h3c, 8'h00);
    prog.pulse_reset(1'b1);
    check({7'h00, eal}, 8'h01);
    $display("test lock bit one done");
    tally_and_finish();
  end
endmodule
